// *** logic/modbus_link_if.sv ***
`timescale 1ns/1ps
interface modbus_link_if;
	logic       q_valid; // Query byte strobe
	logic [7:0] q_data;  // Query byte
	logic       q_last;  // Final byte of query
	logic       r_valid; // Response byte strobe
	logic [7:0] r_data;  // Response byte
	logic       r_last;  // Final byte of response

	modport mst (output q_valid, output q_data, output q_last, input r_valid, input r_data, input r_last);
	modport dev (input q_valid, input q_data, input q_last, output r_valid, output r_data, output r_last);
endinterface : modbus_link_if

// *** logic/modbus_master_end.sv ***
`timescale 1ns/1ps
module modbus_master_end #(
	parameter int MAX_REGS    = modbus_pkg::MAX_REGS,
	parameter int TIMEOUT_CYC = modbus_pkg::TIMEOUT_CYC
) (
	modbus_link_if.mst              LINK,        // Byte link to slave
	input  wire logic               CLK,         // 125 MHz clock
	input  wire logic               RSTN,        // Async reset, active low
	input  wire logic               REQ_VALID,   // Start a query, taken when READY
	input  wire logic [7:0]         REQ_SLAVE,   // Slave address
	input  wire logic [7:0]         REQ_FUNC,    // 06h, 08h or 10h
	input  wire logic [15:0]        REQ_ADDR,    // Register address or sub-function
	input  wire logic [15:0]        REQ_WORD,    // Value, diagnostic data or count
	input  wire logic [16*MAX_REGS-1:0] REQ_DATA, // 10h words, word k at bits 16k
	output logic                    READY,       // Idle, may take a query
	output logic                    REQ_REFUSED, // Query not sent
	output logic                    DONE,        // Transaction finished
	output logic                    DONE_OK,     // Normal reply, echo matched
	output logic                    DONE_EXC,    // Exception reply
	output logic      [7:0]         EXC_CODE     // Exception code
);
	localparam int IW = $clog2(modbus_pkg::MANY_HDR + 2 * MAX_REGS + 1);

	if (MAX_REGS < 1 || MAX_REGS > 16 || TIMEOUT_CYC < 1)
	begin : g_bad_params
		$error("Unsupported master parameters");
	end

	typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT, M_EVAL} state_e;

	state_e             state;
	logic [47:0]        hdr;
	logic [16*MAX_REGS-1:0] data;
	logic [IW-1:0]      qlen;
	logic [IW-1:0]      tx_idx;
	logic [15:0]        tx_crc;
	logic [7:0]         rbuf [8];
	logic [3:0]         rcnt;
	logic [15:0]        rcrc;
	logic [31:0]        wait_cnt;
	logic [7:0]         body;
	logic [IW-1:0]      widx;
	logic               bad_req;

	// Whole 32-bit pairs only, so a query never carries half a parameter
	assign bad_req = (REQ_FUNC == modbus_pkg::FN_WRITE_MANY)
		? (REQ_ADDR[0] || REQ_WORD[0] || REQ_WORD == 16'h0000 || REQ_WORD > 16'(MAX_REGS))
		: (REQ_FUNC != modbus_pkg::FN_WRITE_ONE && REQ_FUNC != modbus_pkg::FN_DIAG);
	assign widx = IW'(tx_idx - IW'(modbus_pkg::MANY_DATA_POS)) >> 1;

	always_comb
	begin
		if (tx_idx < IW'(6))
			body = hdr[8*(5-tx_idx) +: 8];
		else if (tx_idx == IW'(6))
			body = {hdr[6:0], 1'b0};
		else if (tx_idx[0])
			body = data[16*widx + 8 +: 8];
		else
			body = data[16*widx +: 8];
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state       <= M_IDLE;
			hdr         <= 48'h0;
			data        <= '0;
			qlen        <= '0;
			tx_idx      <= '0;
			tx_crc      <= modbus_pkg::CRC_INIT;
			rcnt        <= 4'h0;
			rcrc        <= modbus_pkg::CRC_INIT;
			wait_cnt    <= 32'h0;
			READY       <= 1'b1;
			REQ_REFUSED <= 1'b0;
			DONE        <= 1'b0;
			DONE_OK     <= 1'b0;
			DONE_EXC    <= 1'b0;
			EXC_CODE    <= 8'h00;
			LINK.q_valid <= 1'b0;
			LINK.q_data  <= 8'h00;
			LINK.q_last  <= 1'b0;
		end
		else
		begin
			REQ_REFUSED  <= 1'b0;
			DONE         <= 1'b0;
			LINK.q_valid <= 1'b0;
			LINK.q_last  <= 1'b0;
			unique case (state)
				M_IDLE:
				begin
					if (REQ_VALID && bad_req)
						REQ_REFUSED <= 1'b1;
					else if (REQ_VALID)
					begin
						hdr    <= {REQ_SLAVE, REQ_FUNC, REQ_ADDR, REQ_WORD};
						data   <= REQ_DATA;
						qlen   <= (REQ_FUNC == modbus_pkg::FN_WRITE_MANY)
							? IW'(modbus_pkg::MANY_DATA_POS + 2 * REQ_WORD) : IW'(modbus_pkg::ECHO_LEN);
						tx_idx <= '0;
						tx_crc <= modbus_pkg::CRC_INIT;
						READY  <= 1'b0;
						state  <= M_SEND;
					end
				end
				M_SEND:
				begin
					LINK.q_valid <= 1'b1;
					tx_idx       <= IW'(tx_idx + IW'(1));
					if (tx_idx < qlen)
					begin
						LINK.q_data <= body;
						tx_crc      <= modbus_pkg::crc_step(tx_crc, body);
					end
					else if (tx_idx == qlen)
						LINK.q_data <= tx_crc[7:0];
					else
					begin
						LINK.q_data <= tx_crc[15:8];
						LINK.q_last <= 1'b1;
						rcnt        <= 4'h0;
						rcrc        <= modbus_pkg::CRC_INIT;
						wait_cnt    <= 32'h0;
						state       <= M_WAIT;
					end
				end
				M_WAIT:
				begin
					wait_cnt <= wait_cnt + 32'h1;
					if (LINK.r_valid)
					begin
						rcrc <= modbus_pkg::crc_step(rcrc, LINK.r_data);
						if (rcnt < 4'h8)
							rcnt <= rcnt + 4'h1;
						if (LINK.r_last)
							state <= M_EVAL;
					end
					else if (wait_cnt >= 32'(TIMEOUT_CYC))
					begin
						// A dropped query gets no reply; give up rather than hang
						DONE     <= 1'b1;
						DONE_OK  <= 1'b0;
						DONE_EXC <= 1'b0;
						READY    <= 1'b1;
						state    <= M_IDLE;
					end
				end
				M_EVAL:
				begin
					DONE     <= 1'b1;
					DONE_OK  <= (rcrc == 16'h0000) && (rcnt == 4'h8)
						&& ({rbuf[0], rbuf[1], rbuf[2], rbuf[3], rbuf[4], rbuf[5]} == hdr);
					DONE_EXC <= (rcrc == 16'h0000) && (rcnt == 4'h5)
						&& (rbuf[1] == (hdr[39:32] | modbus_pkg::FN_EXC_FLAG));
					EXC_CODE <= rbuf[2];
					READY    <= 1'b1;
					state    <= M_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (state == M_WAIT && LINK.r_valid && rcnt < 4'h8)
			rbuf[rcnt[2:0]] <= LINK.r_data;
	end
endmodule : modbus_master_end

// *** logic/modbus_pkg.sv ***
package modbus_pkg;
	localparam logic [7:0]  FN_WRITE_ONE  = 8'h06;
	localparam logic [7:0]  FN_DIAG       = 8'h08;
	localparam logic [7:0]  FN_WRITE_MANY = 8'h10;
	localparam logic [7:0]  FN_EXC_FLAG   = 8'h80;
	localparam logic [7:0]  EXC_BAD_FUNC  = 8'h01;
	localparam logic [7:0]  EXC_BAD_ADDR  = 8'h02;
	localparam logic [7:0]  EXC_BAD_DATA  = 8'h03;
	localparam logic [7:0]  EXC_SLAVE     = 8'h04;
	localparam logic [15:0] SUB_ECHO      = 16'h0000;
	localparam logic [16:0] ADDR_LIMIT    = 17'h02000;
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'ha001;
	localparam int          MAX_REGS      = 16;
	localparam int          FIXED_LEN     = 8;
	localparam int          MANY_HDR      = 9;
	localparam int          ECHO_LEN      = 6;
	localparam int          EXC_LEN       = 3;
	localparam int          MANY_DATA_POS = 7;
	localparam int          TIMEOUT_CYC   = 1024;

	// Reflected CRC-16, one byte; a whole frame with its check appended leaves zero
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step
endpackage : modbus_pkg

// *** logic/modbus_slave_end.sv ***
// Operation
// - 06h stores one word, echoes whole query
// - Master uses 10h for 32-bit parameters
// - 08h sub-function 00h echoes query unchanged
// - Master checks echoed diagnostic data matches
// - 10h writes up to 16 consecutive registers
// - Registers committed in ascending address order
// - Earlier writes kept on later exception
// - Master sends both halves together
// - 10h: address, count, bytecount, words high-first
// - 10h reply: address, function, start, count, check
// - CRC-16 ends every frame, low byte first
// - Address beyond 1FFFh gives exception 02h; a 10h run whose last register is 1FFFh gets it too
// - Bad count or bytecount gives exception 03h
// - Even address upper half, odd lower
// - Other diagnostic sub-function gives exception 01h
`timescale 1ns/1ps
module modbus_slave_end #(
	parameter int MAX_REGS = modbus_pkg::MAX_REGS
) (
	modbus_link_if.dev        LINK,      // Byte link to master
	input  wire logic         CLK,       // 125 MHz clock
	input  wire logic         RSTN,      // Async reset, active low
	input  wire logic [7:0]   OWN_ADDR,  // This slave's address
	input  wire logic         WR_REJECT, // Value out of range, valid while WR_EN
	output logic              WR_EN,     // Register write strobe
	output logic      [15:0]  WR_ADDR,   // Register address
	output logic      [15:0]  WR_DATA    // Register value
);
	localparam int FRAME_MAX = modbus_pkg::MANY_HDR + 2 * MAX_REGS;
	localparam int IW        = $clog2(FRAME_MAX + 1);

	if (MAX_REGS < 1 || MAX_REGS > 16)
	begin : g_bad_regs
		$error("MAX_REGS must lie in 1..16");
	end

	typedef enum logic [2:0] {S_RX, S_CHECK, S_WRITE, S_WACK, S_SEND} state_e;

	state_e        state;
	logic [7:0]    fbuf [FRAME_MAX];
	logic [IW-1:0] rx_cnt;
	logic          overflow;
	logic [15:0]   rx_crc;
	logic [15:0]   tx_crc;
	logic [IW-1:0] tx_idx;
	logic [IW-1:0] resp_len;
	logic          exc;
	logic [7:0]    exc_code;
	logic [15:0]   wr_ptr;
	logic [15:0]   left;
	logic [IW-1:0] dptr;

	logic [15:0] f_start;
	logic [15:0] f_word;
	logic [16:0] need_len;
	logic [16:0] end_addr;
	logic        chk_drop;
	logic        chk_write;
	logic [7:0]  chk_code;
	logic [7:0]  tx_byte;

	assign f_start  = {fbuf[2], fbuf[3]};
	assign f_word   = {fbuf[4], fbuf[5]};
	assign need_len = 17'(modbus_pkg::MANY_HDR) + {f_word, 1'b0};
	assign end_addr = {1'b0, f_start} + {1'b0, f_word};

	always_comb
	begin
		chk_drop  = (rx_crc != 16'h0000) || (rx_cnt < IW'(4)) || (fbuf[0] != OWN_ADDR);
		chk_write = 1'b0;
		chk_code  = 8'h00;
		case (fbuf[1])
			modbus_pkg::FN_WRITE_ONE:
			begin
				if (rx_cnt != IW'(modbus_pkg::FIXED_LEN))
					chk_code = modbus_pkg::EXC_BAD_DATA;
				else if ({1'b0, f_start} >= modbus_pkg::ADDR_LIMIT)
					chk_code = modbus_pkg::EXC_BAD_ADDR;
				else
					chk_write = 1'b1;
			end
			modbus_pkg::FN_DIAG:
			begin
				if (f_start != modbus_pkg::SUB_ECHO)
					chk_code = modbus_pkg::EXC_BAD_FUNC;
				else if (rx_cnt != IW'(modbus_pkg::FIXED_LEN))
					chk_code = modbus_pkg::EXC_BAD_DATA;
			end
			modbus_pkg::FN_WRITE_MANY:
			begin
				if (f_word == 16'h0000 || f_word > 16'(MAX_REGS) || overflow
					|| fbuf[6] != {f_word[6:0], 1'b0} || {{(17-IW){1'b0}}, rx_cnt} != need_len)
					chk_code = modbus_pkg::EXC_BAD_DATA;
				else if (end_addr >= modbus_pkg::ADDR_LIMIT)
					chk_code = modbus_pkg::EXC_BAD_ADDR;
				else
					chk_write = 1'b1;
			end
			default:
				chk_code = modbus_pkg::EXC_BAD_FUNC;
		endcase
	end

	// Response body is the head of the query, or its exception rewrite
	always_comb
	begin
		if (tx_idx == resp_len)
			tx_byte = tx_crc[7:0];
		else if (tx_idx > resp_len)
			tx_byte = tx_crc[15:8];
		else if (exc && tx_idx == IW'(1))
			tx_byte = fbuf[1] | modbus_pkg::FN_EXC_FLAG;
		else if (exc && tx_idx == IW'(2))
			tx_byte = exc_code;
		else
			tx_byte = fbuf[tx_idx];
	end

	// Frame capture; bytes arriving while busy are ignored, master is half-duplex
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rx_cnt   <= '0;
			overflow <= 1'b0;
			rx_crc   <= modbus_pkg::CRC_INIT;
		end
		else if (state == S_RX && LINK.q_valid)
		begin
			rx_crc <= modbus_pkg::crc_step(rx_crc, LINK.q_data);
			if (rx_cnt < IW'(FRAME_MAX))
				rx_cnt <= rx_cnt + IW'(1);
			else
				overflow <= 1'b1;
		end
		else if (state == S_CHECK)
		begin
			rx_cnt   <= '0;
			overflow <= 1'b0;
			rx_crc   <= modbus_pkg::CRC_INIT;
		end
	end

	// Buffer holds no reset; it is only read after a full frame refills it
	always_ff @(posedge CLK)
	begin
		if (state == S_RX && LINK.q_valid && rx_cnt < IW'(FRAME_MAX))
			fbuf[rx_cnt] <= LINK.q_data;
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state    <= S_RX;
			resp_len <= '0;
			exc      <= 1'b0;
			exc_code <= 8'h00;
			wr_ptr   <= 16'h0000;
			left     <= 16'h0000;
			dptr     <= '0;
			WR_EN    <= 1'b0;
			WR_ADDR  <= 16'h0000;
			WR_DATA  <= 16'h0000;
		end
		else
		begin
			unique case (state)
				S_RX:
				begin
					if (LINK.q_valid && LINK.q_last)
						state <= S_CHECK;
				end
				S_CHECK:
				begin
					exc      <= (chk_code != 8'h00);
					exc_code <= chk_code;
					resp_len <= (chk_code != 8'h00) ? IW'(modbus_pkg::EXC_LEN) : IW'(modbus_pkg::ECHO_LEN);
					wr_ptr   <= f_start;
					left     <= (fbuf[1] == modbus_pkg::FN_WRITE_ONE) ? 16'h0001 : f_word;
					dptr     <= (fbuf[1] == modbus_pkg::FN_WRITE_ONE) ? IW'(4) : IW'(modbus_pkg::MANY_DATA_POS);
					if (chk_drop)
						state <= S_RX;
					else if (chk_write)
						state <= S_WRITE;
					else
						state <= S_SEND;
				end
				S_WRITE:
				begin
					WR_EN   <= 1'b1;
					WR_ADDR <= wr_ptr;
					WR_DATA <= {fbuf[dptr], fbuf[IW'(dptr + IW'(1))]};
					state   <= S_WACK;
				end
				S_WACK:
				begin
					WR_EN <= 1'b0;
					if (WR_REJECT)
					begin
						// Words already committed stay; no rollback
						exc      <= 1'b1;
						exc_code <= modbus_pkg::EXC_SLAVE;
						resp_len <= IW'(modbus_pkg::EXC_LEN);
						state    <= S_SEND;
					end
					else if (left == 16'h0001)
						state <= S_SEND;
					else
					begin
						wr_ptr <= wr_ptr + 16'h0001;
						left   <= left - 16'h0001;
						dptr   <= IW'(dptr + IW'(2));
						state  <= S_WRITE;
					end
				end
				S_SEND:
				begin
					if (tx_idx > resp_len)
						state <= S_RX;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			tx_idx       <= '0;
			tx_crc       <= modbus_pkg::CRC_INIT;
			LINK.r_valid <= 1'b0;
			LINK.r_data  <= 8'h00;
			LINK.r_last  <= 1'b0;
		end
		else if (state == S_SEND)
		begin
			LINK.r_valid <= 1'b1;
			LINK.r_data  <= tx_byte;
			LINK.r_last  <= (tx_idx > resp_len);
			tx_idx       <= IW'(tx_idx + IW'(1));
			if (tx_idx < resp_len)
				tx_crc <= modbus_pkg::crc_step(tx_crc, tx_byte);
		end
		else
		begin
			tx_idx       <= '0;
			tx_crc       <= modbus_pkg::CRC_INIT;
			LINK.r_valid <= 1'b0;
			LINK.r_last  <= 1'b0;
		end
	end
endmodule : modbus_slave_end

// *** sim/modbus_link_assertions.sv ***
`timescale 1ns/1ps
module modbus_link_assertions (
	input  wire logic       CLK,     // Clock
	input  wire logic       RSTN,    // Reset, active low
	input  wire logic       q_valid, // Query strobe
	input  wire logic [7:0] q_data,  // Query byte
	input  wire logic       q_last,  // Query end
	input  wire logic       r_valid, // Reply strobe
	input  wire logic [7:0] r_data,  // Reply byte
	input  wire logic       r_last   // Reply end
);
	logic [15:0] qcrc;
	logic [15:0] rcrc;
	logic [5:0]  qcnt;
	logic [7:0]  qa;
	logic [7:0]  qf;

	// Own copy, so a slip shared by both ends still shows
	function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
		return r;
	endfunction : step

	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN)
			qcrc <= 16'hffff;
		else if (q_valid)
			qcrc <= q_last ? 16'hffff : step(qcrc, q_data);

	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN)
			rcrc <= 16'hffff;
		else if (r_valid)
			rcrc <= r_last ? 16'hffff : step(rcrc, r_data);

	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN)
		begin
			qcnt <= 6'h00;
			qa <= 8'h00;
			qf <= 8'h00;
		end
		else if (q_valid)
		begin
			qcnt <= q_last ? 6'h00 : qcnt + 6'h01;
			if (qcnt == 6'h00)
				qa <= q_data;
			if (qcnt == 6'h01)
				qf <= q_data;
		end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	sequence s_norm;
		$rose(r_valid) ##1 !r_data[7];
	endsequence
	sequence s_exc;
		$rose(r_valid) ##1 r_data[7];
	endsequence

	a_qlast_valid: assert property (q_last |-> q_valid) else $error("query end without byte");
	a_rlast_valid: assert property (r_last |-> r_valid) else $error("reply end without byte");
	a_half_duplex: assert property (q_valid |-> !r_valid) else $error("query and reply overlap");
	a_query_burst: assert property ($rose(q_valid) |-> q_valid[*8]) else $error("query too short");
	a_master_waits: assert property (q_last |=> !q_valid[*8]) else $error("query follows query");
	a_query_crc: assert property (q_last |-> step(qcrc, q_data) == 16'h0000)
		else $error("query check wrong");
	a_reply_crc: assert property (r_last |-> step(rcrc, r_data) == 16'h0000)
		else $error("reply check wrong");
	a_reply_slave: assert property ($rose(r_valid) |-> r_data == qa) else $error("reply slave wrong");
	a_reply_func: assert property ($rose(r_valid) |=> r_data == qf || r_data == (qf | 8'h80))
		else $error("reply function wrong");
	a_norm_len: assert property (s_norm |=> (r_valid && !r_last)[*5] ##1 r_last)
		else $error("normal reply length wrong");
	a_exc_len: assert property (s_exc |=> (r_valid && !r_last)[*2] ##1 r_last)
		else $error("exception reply length wrong");
	a_reply_end: assert property (r_last |=> !r_valid) else $error("reply runs on");
endmodule : modbus_link_assertions

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic         CLK;
	logic         RSTN;
	logic         REQ_VALID;
	logic [7:0]   REQ_SLAVE;
	logic [7:0]   REQ_FUNC;
	logic [15:0]  REQ_ADDR;
	logic [15:0]  REQ_WORD;
	logic [255:0] REQ_DATA;
	logic         READY;
	logic         REQ_REFUSED;
	logic         DONE;
	logic         DONE_OK;
	logic         DONE_EXC;
	logic [7:0]   EXC_CODE;
	logic [7:0]   OWN_ADDR;
	logic         WR_REJECT;
	logic         WR_EN;
	logic [15:0]  WR_ADDR;
	logic [15:0]  WR_DATA;
	logic [15:0]  qb[$];
	logic [15:0]  rb[$];
	logic [15:0]  la[$];
	logic [15:0]  ld[$];
	int           miscompares;
	int           n_checks;
	int           rej_at;
	int           cyc;

	modbus_link_if link();

	modbus_master_end #(.MAX_REGS(16), .TIMEOUT_CYC(64)) u_modbus_master_end (
		.LINK(link), .CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_SLAVE(REQ_SLAVE),
		.REQ_FUNC(REQ_FUNC), .REQ_ADDR(REQ_ADDR), .REQ_WORD(REQ_WORD), .REQ_DATA(REQ_DATA),
		.READY(READY), .REQ_REFUSED(REQ_REFUSED), .DONE(DONE), .DONE_OK(DONE_OK), .DONE_EXC(DONE_EXC),
		.EXC_CODE(EXC_CODE));

	modbus_slave_end #(.MAX_REGS(16)) u_modbus_slave_end (
		.LINK(link), .CLK(CLK), .RSTN(RSTN), .OWN_ADDR(OWN_ADDR), .WR_REJECT(WR_REJECT),
		.WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA));

	modbus_link_assertions u_modbus_link_assertions (
		.CLK(CLK), .RSTN(RSTN), .q_valid(link.q_valid), .q_data(link.q_data), .q_last(link.q_last),
		.r_valid(link.r_valid), .r_data(link.r_data), .r_last(link.r_last));

	initial
	begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	always @(posedge CLK)
	begin
		if (link.q_valid)
			qb.push_back({8'h00, link.q_data});
		if (link.r_valid)
			rb.push_back({8'h00, link.r_data});
		if (WR_EN)
		begin
			la.push_back(WR_ADDR);
			ld.push_back(WR_DATA);
		end
	end

	// Refuses the write that follows rej_at earlier ones
	always @(negedge CLK)
		WR_REJECT <= WR_EN && la.size() == rej_at;

	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic run(input logic [7:0] own, input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
		input logic [15:0] wd, input logic ok, input logic exc, input logic [7:0] cd, input int nw);
		int k;
		@(negedge CLK);
		qb.delete();
		rb.delete();
		la.delete();
		ld.delete();
		OWN_ADDR = own;
		REQ_SLAVE = sl;
		REQ_FUNC = fn;
		REQ_ADDR = ad;
		REQ_WORD = wd;
		REQ_VALID = 1'b1;
		@(negedge CLK);
		REQ_VALID = 1'b0;
		chk("busy", 16'h0000, {15'h0000, READY});
		k = 0;
		while (DONE !== 1'b1 && k < 3000)
		begin
			@(negedge CLK);
			k++;
		end
		chk("done", 16'h0001, {15'h0000, DONE});
		chk("ready", 16'h0001, {15'h0000, READY});
		chk("ok", {15'h0000, ok}, {15'h0000, DONE_OK});
		chk("exc", {15'h0000, exc}, {15'h0000, DONE_EXC});
		if (exc)
			chk("code", {8'h00, cd}, {8'h00, EXC_CODE});
		chk("writes", nw[15:0], 16'(la.size()));
	endtask : run

	// A refused query must leave the link silent and the master idle
	task automatic refuse(input logic [15:0] ad, input logic [15:0] wd);
		@(negedge CLK);
		qb.delete();
		REQ_SLAVE = 8'h04;
		REQ_FUNC = 8'h10;
		REQ_ADDR = ad;
		REQ_WORD = wd;
		REQ_VALID = 1'b1;
		@(negedge CLK);
		REQ_VALID = 1'b0;
		chk("refused", 16'h0001, {15'h0000, REQ_REFUSED});
		chk("ready", 16'h0001, {15'h0000, READY});
		repeat (3) @(negedge CLK);
		chk("refused", 16'h0000, {15'h0000, REQ_REFUSED});
		chk("qbytes", 16'h0000, 16'(qb.size()));
	endtask : refuse

	initial
	begin
		RSTN = 1'b0;
		REQ_VALID = 1'b0;
		REQ_SLAVE = 8'h00;
		REQ_FUNC = 8'h00;
		REQ_ADDR = 16'h0000;
		REQ_WORD = 16'h0000;
		REQ_DATA = '0;
		OWN_ADDR = 8'h01;
		rej_at = -1;
		repeat (20) @(negedge CLK);
		RSTN = 1'b1;
		run(8'h02, 8'h02, 8'h06, 16'h024b, 16'h0050, 1, 0, 8'h00, 1);
		chk("wa", 16'h024b, la[0]);
		chk("wd", 16'h0050, ld[0]);
		chk("crcl", 16'h00f8, qb[6]);
		chk("crch", 16'h006b, qb[7]);
		for (int i = 0; i < 8; i++)
			chk("echo", qb[i], rb[i]);
		run(8'h03, 8'h03, 8'h08, 16'h0000, 16'h1234, 1, 0, 8'h00, 0);
		chk("crcl", 16'h00ec, qb[6]);
		chk("crch", 16'h009e, qb[7]);
		for (int i = 0; i < 8; i++)
			chk("echo", qb[i], rb[i]);
		run(8'h03, 8'h03, 8'h08, 16'h0001, 16'h1234, 0, 1, 8'h01, 0);
		REQ_DATA[95:0] = {16'ha120, 16'h0007, 16'h4e20, 16'h0000, 16'h2710, 16'h0000};
		run(8'h04, 8'h04, 8'h10, 16'h0604, 16'h0006, 1, 0, 8'h00, 6);
		chk("qbytes", 16'd21, 16'(qb.size()));
		chk("count", 16'h000c, qb[6]);
		chk("crcl", 16'h001d, qb[19]);
		chk("crch", 16'h00a9, qb[20]);
		chk("rlen", 16'd8, 16'(rb.size()));
		chk("rcrch", 16'h0017, rb[7]);
		for (int i = 0; i < 6; i++)
		begin
			chk("rhead", qb[i], rb[i]);
			chk("wa", 16'h0604 + i[15:0], la[i]);
			chk("wd", REQ_DATA[16*i+:16], ld[i]);
		end
		for (int i = 0; i < 16; i++)
			REQ_DATA[16*i+:16] = 16'h0111 * i[15:0];
		run(8'h04, 8'h04, 8'h10, 16'h1fe0, 16'h0010, 1, 0, 8'h00, 16);
		chk("wa", 16'h1fef, la[15]);
		chk("wd", 16'h0fff, ld[15]);
		run(8'h04, 8'h04, 8'h10, 16'h1ff0, 16'h0010, 0, 1, 8'h02, 0);
		run(8'h02, 8'h02, 8'h06, 16'h2000, 16'h0050, 0, 1, 8'h02, 0);
		chk("rlen", 16'd5, 16'(rb.size()));
		chk("rfunc", 16'h0086, rb[1]);
		rej_at = 2;
		run(8'h04, 8'h04, 8'h10, 16'h0604, 16'h0004, 0, 1, 8'h04, 3);
		chk("wa", 16'h0605, la[1]);
		rej_at = -1;
		run(8'h05, 8'h02, 8'h06, 16'h024b, 16'h0050, 0, 0, 8'h00, 0);
		chk("rlen", 16'd0, 16'(rb.size()));
		refuse(16'h0605, 16'h0002);
		refuse(16'h0604, 16'h0003);
		refuse(16'h0604, 16'h0012);
		results();
	end
endmodule : testbench
